// ---- startup_consts.vh ----
`ifndef STARTUP_CONSTS_VH
`define STARTUP_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define SS_CLOCK_KHZ 10000
`define SS_CHECK_MS 9'h005
`define SS_MIN_DELAY_MS 8'h02

// ****************************************
// Register byte offsets
// ****************************************
`define SS_REG_CONTROL 5'h00
`define SS_REG_DELAY 5'h04
`define SS_REG_RAMP 5'h08
`define SS_REG_NOMINAL 5'h0C
`define SS_REG_STATUS 5'h10
`define SS_REG_TARGET 5'h14

// ****************************************
// Control and status bits and reset values
// ****************************************
`define SS_CTRL_RESTORE 0
`define SS_CTRL_PRECISE 1
`define SS_STATUS_MEMORY 8
`define SS_NOMINAL_RESET 12'h800

// ****************************************
// Three-state pin codes
// ****************************************
`define SS_PIN_LOW 2'h0
`define SS_PIN_OPEN 2'h1
`define SS_PIN_HIGH 2'h2

// ****************************************
// Strap times in milliseconds and the resistor code limit
// ****************************************
`define SS_MS_0 8'h00
`define SS_MS_1 8'h01
`define SS_MS_2 8'h02
`define SS_MS_5 8'h05
`define SS_MS_10 8'h0A
`define SS_MS_20 8'h14
`define SS_MS_50 8'h32
`define SS_MS_100 8'h64
`define SS_MS_200 8'hC8
`define SS_RES_STEP_MS 8'h0A
`define SS_RES_MAX_CODE 5'h14

`endif

// ---- soft_start_ramp.v ----
`timescale 1ns/1ps
`include "startup_consts.vh"
module soft_start_ramp #(
    parameter CYCLES_PER_MS = `SS_CLOCK_KHZ,
    parameter TARGET_WIDTH = 12
) (
    input wire core_clk,
    input wire reset_n,
    input wire start,
    input wire hold,
    input wire [7:0] rampMs,
    input wire [TARGET_WIDTH-1:0] nominal,
    output reg [TARGET_WIDTH-1:0] target,
    output reg active,
    output reg done
);
    reg [31:0] totalCycles;
    reg [31:0] elapsed;
    reg [31:0] acc;
    reg [TARGET_WIDTH-1:0] goal;
    wire [31:0] accNext;
    wire [TARGET_WIDTH-1:0] one;

    assign accNext = acc + {{(32-TARGET_WIDTH){1'b0}}, goal};
    assign one = {{(TARGET_WIDTH-1){1'b0}}, 1'b1};

    // Steps spread evenly over the ramp time; the target only counts up while not held, and hold clears it to zero.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            target <= {TARGET_WIDTH{1'b0}};
            goal <= {TARGET_WIDTH{1'b0}};
            totalCycles <= 32'h0;
            elapsed <= 32'h0;
            acc <= 32'h0;
            active <= 1'b0;
            done <= 1'b0;
        end else if (hold) begin
            target <= {TARGET_WIDTH{1'b0}};
            active <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            goal <= nominal;
            elapsed <= 32'h0;
            acc <= 32'h0;
            totalCycles <= {24'h0, rampMs} * CYCLES_PER_MS;
            if (rampMs == `SS_MS_0) begin
                target <= nominal;
                done <= 1'b1;
                active <= 1'b0;
            end else begin
                active <= 1'b1;
                done <= 1'b0;
            end
        end else if (active) begin
            elapsed <= elapsed + 32'h1;
            if (elapsed + 32'h1 >= totalCycles) begin
                target <= goal;
                active <= 1'b0;
                done <= 1'b1;
            end else if (accNext >= totalCycles) begin
                acc <= accNext - totalCycles;
                if (target < goal) begin
                    target <= target + one;
                end
            end else begin
                acc <= accNext;
            end
        end
    end
endmodule

// ---- startup_softstart_sequencer.v ----
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "startup_consts.vh"
module startup_softstart_sequencer #(
    parameter CYCLES_PER_MS = `SS_CLOCK_KHZ,
    parameter TARGET_WIDTH = 12,
    parameter [TARGET_WIDTH-1:0] NOMINAL_DEFAULT = `SS_NOMINAL_RESET
) (
    input wire core_clk,
    input wire reset_n,
    input wire enable,
    input wire [1:0] delaySelectLow,
    input wire [1:0] delaySelectHigh,
    input wire [1:0] rampSelect,
    input wire delayResistorFound,
    input wire [4:0] delayResistorCode,
    input wire rampResistorFound,
    input wire [4:0] rampResistorCode,
    input wire storedValid,
    input wire [7:0] storedDelayMs,
    input wire [7:0] storedRampMs,
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    output reg deviceReady,
    output wire [TARGET_WIDTH-1:0] outputTarget,
    output wire rampActive,
    output wire rampDone
);

    // ****************************************
    // States
    // ****************************************
    localparam [5:0] ST_CHECK = 6'h01;
    localparam [5:0] ST_STRAP = 6'h02;
    localparam [5:0] ST_READY = 6'h04;
    localparam [5:0] ST_DELAY = 6'h08;
    localparam [5:0] ST_RAMP = 6'h10;
    localparam [5:0] ST_ON = 6'h20;

    // ****************************************
    // Functions
    // ****************************************
    function [7:0] decodeResistor;
        input [4:0] code;
        begin
            if (code > `SS_RES_MAX_CODE) begin
                decodeResistor = `SS_MS_200;
            end else begin
                decodeResistor = {3'h0, code} * `SS_RES_STEP_MS;
            end
        end
    endfunction

    function [7:0] decodeDelay;
        input [1:0] high;
        input [1:0] low;
        begin
            case (high)
                `SS_PIN_LOW: begin
                    decodeDelay = (low == `SS_PIN_LOW) ? `SS_MS_0 :
                        (low == `SS_PIN_HIGH) ? `SS_MS_2 : `SS_MS_1;
                end
                `SS_PIN_HIGH: begin
                    decodeDelay = (low == `SS_PIN_LOW) ? `SS_MS_50 :
                        (low == `SS_PIN_HIGH) ? `SS_MS_200 : `SS_MS_100;
                end
                default: begin
                    decodeDelay = (low == `SS_PIN_LOW) ? `SS_MS_5 :
                        (low == `SS_PIN_HIGH) ? `SS_MS_20 : `SS_MS_10;
                end
            endcase
        end
    endfunction

    function [7:0] decodeRamp;
        input [1:0] code;
        begin
            case (code)
                `SS_PIN_LOW: begin
                    decodeRamp = `SS_MS_0;
                end
                `SS_PIN_HIGH: begin
                    decodeRamp = `SS_MS_10;
                end
                default: begin
                    decodeRamp = `SS_MS_5;
                end
            endcase
        end
    endfunction

    // Merges the enabled byte lanes of new data over old data.
    function [31:0] mergeBytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] lanes;
        integer i;
        begin
            mergeBytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    mergeBytes[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************
    // Storage
    // ****************************************
    reg [5:0] state;
    reg [31:0] prescale;
    reg msTick;
    reg [8:0] msCount;
    reg [7:0] cfgDelayMs;
    reg [7:0] cfgRampMs;
    reg [TARGET_WIDTH-1:0] nominal;
    reg preciseDelay;
    reg loadedFromMemory;
    reg rampStart;
    reg [31:0] next_readdata;

    wire request;
    wire busOpen;
    wire accept;
    wire writeTaken;
    wire restoreCmd;
    wire restartTick;
    wire [7:0] effDelayMs;
    wire [8:0] delayTicks;
    wire rampHold;
    wire [31:0] ctrlMerged;
    wire [31:0] delayMerged;
    wire [31:0] rampMerged;
    wire [31:0] nominalMerged;

    assign request = read | write;
    assign busOpen = ~(state[0] | state[1]);
    assign accept = request & ~waitrequest;
    assign writeTaken = accept & write & busOpen;
    assign ctrlMerged = mergeBytes(32'h0, writedata, byteenable);
    assign delayMerged = mergeBytes({24'h0, cfgDelayMs}, writedata, byteenable);
    assign rampMerged = mergeBytes({24'h0, cfgRampMs}, writedata, byteenable);
    assign nominalMerged = mergeBytes({{(32-TARGET_WIDTH){1'b0}}, nominal}, writedata, byteenable);
    assign restoreCmd = writeTaken && (address == `SS_REG_CONTROL) && ctrlMerged[`SS_CTRL_RESTORE];

    // The floor replaces any short setting, including 0 and 1 ms.
    assign effDelayMs = (cfgDelayMs < `SS_MIN_DELAY_MS) ? `SS_MIN_DELAY_MS : cfgDelayMs;

    // Free-running ticks need one extra tick so the wait is never short.
    assign delayTicks = preciseDelay ? {1'b0, effDelayMs} : {1'b0, effDelayMs} + 9'h001;

    assign restartTick = restoreCmd | (state[2] & enable & preciseDelay);
    assign rampHold = ~(state[3] | state[4] | state[5]);

    // ****************************************
    // Millisecond time base
    // ****************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale <= 32'h0;
            msTick <= 1'b0;
        end else if (restartTick) begin
            prescale <= 32'h0;
            msTick <= 1'b0;
        end else if (prescale == CYCLES_PER_MS - 1) begin
            prescale <= 32'h0;
            msTick <= 1'b1;
        end else begin
            prescale <= prescale + 32'h1;
            msTick <= 1'b0;
        end
    end

    // ****************************************
    // Start-up sequence
    // ****************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_CHECK;
            msCount <= 9'h000;
            cfgDelayMs <= `SS_MS_0;
            cfgRampMs <= `SS_MS_0;
            loadedFromMemory <= 1'b0;
            rampStart <= 1'b0;
            deviceReady <= 1'b0;
        end else begin
            rampStart <= 1'b0;
            if (restoreCmd) begin
                state <= ST_CHECK;
                msCount <= 9'h000;
                loadedFromMemory <= 1'b0;
                deviceReady <= 1'b0;
            end else begin
                case (state)
                    ST_CHECK: begin
                        if (msTick) begin
                            if (msCount + 9'h001 == `SS_CHECK_MS) begin
                                state <= ST_STRAP;
                                msCount <= 9'h000;
                                if (storedValid) begin
                                    cfgDelayMs <= storedDelayMs;
                                    cfgRampMs <= storedRampMs;
                                    loadedFromMemory <= 1'b1;
                                end
                            end else begin
                                msCount <= msCount + 9'h001;
                            end
                        end
                    end
                    ST_STRAP: begin
                        // Stored values stand; pins fill in when memory was empty.
                        if (!loadedFromMemory) begin
                            if (delayResistorFound) begin
                                cfgDelayMs <= decodeResistor(delayResistorCode);
                            end else begin
                                cfgDelayMs <= decodeDelay(delaySelectHigh, delaySelectLow);
                            end
                            if (rampResistorFound) begin
                                cfgRampMs <= decodeResistor(rampResistorCode);
                            end else begin
                                cfgRampMs <= decodeRamp(rampSelect);
                            end
                        end
                        state <= ST_READY;
                        deviceReady <= 1'b1;
                    end
                    ST_READY: begin
                        if (enable) begin
                            state <= ST_DELAY;
                            msCount <= 9'h000;
                        end
                    end
                    ST_DELAY: begin
                        if (!enable) begin
                            state <= ST_READY;
                        end else if (msTick) begin
                            if (msCount + 9'h001 >= delayTicks) begin
                                state <= ST_RAMP;
                                rampStart <= 1'b1;
                            end else begin
                                msCount <= msCount + 9'h001;
                            end
                        end
                    end
                    ST_RAMP: begin
                        if (!enable) begin
                            state <= ST_READY;
                        end else if (rampDone) begin
                            state <= ST_ON;
                        end
                    end
                    ST_ON: begin
                        if (!enable) begin
                            state <= ST_READY;
                        end
                    end
                    default: begin
                        state <= ST_CHECK;
                    end
                endcase
                // Bus values replace the loaded ones until the next reload.
                if (writeTaken && address == `SS_REG_DELAY) begin
                    cfgDelayMs <= delayMerged[7:0];
                end
                if (writeTaken && address == `SS_REG_RAMP) begin
                    cfgRampMs <= rampMerged[7:0];
                end
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            preciseDelay <= 1'b0;
            nominal <= NOMINAL_DEFAULT;
        end else begin
            if (writeTaken && address == `SS_REG_CONTROL) begin
                preciseDelay <= ctrlMerged[`SS_CTRL_PRECISE];
            end
            if (writeTaken && address == `SS_REG_NOMINAL) begin
                nominal <= nominalMerged[TARGET_WIDTH-1:0];
            end
        end
    end

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    always @* begin
        next_readdata = 32'h0;
        if (address == `SS_REG_CONTROL) begin
            next_readdata[`SS_CTRL_PRECISE] = preciseDelay;
        end else if (address == `SS_REG_DELAY) begin
            next_readdata[7:0] = cfgDelayMs;
        end else if (address == `SS_REG_RAMP) begin
            next_readdata[7:0] = cfgRampMs;
        end else if (address == `SS_REG_NOMINAL) begin
            next_readdata[TARGET_WIDTH-1:0] = nominal;
        end else if (address == `SS_REG_STATUS) begin
            next_readdata[5:0] = state;
            next_readdata[`SS_STATUS_MEMORY] = loadedFromMemory;
        end else if (address == `SS_REG_TARGET) begin
            next_readdata[TARGET_WIDTH-1:0] = outputTarget;
        end
    end

    // One wait cycle, then one cycle with waitrequest low.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if (request && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= next_readdata;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // ****************************************
    // Soft-start ramp
    // ****************************************
    soft_start_ramp #(
        .CYCLES_PER_MS(CYCLES_PER_MS),
        .TARGET_WIDTH(TARGET_WIDTH)
    ) rampUnit (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(rampStart),
        .hold(rampHold),
        .rampMs(cfgRampMs),
        .nominal(nominal),
        .target(outputTarget),
        .active(rampActive),
        .done(rampDone)
    );

endmodule

// ---- startup_sequencer_props.sv ----
`timescale 1ns/1ps
module startup_sequencer_props #(
    parameter CYCLES_PER_MS = 10000,
    parameter TARGET_WIDTH = 12
) (
    input wire core_clk,
    input wire reset_n,
    input wire enable,
    input wire read,
    input wire write,
    input wire waitrequest,
    input wire deviceReady,
    input wire [TARGET_WIDTH-1:0] outputTarget,
    input wire rampActive,
    input wire rampDone
);
    localparam int CHECK_CYC = 5 * CYCLES_PER_MS - 1;
    localparam int FLOOR_CYC = 2 * CYCLES_PER_MS - 1;
    int notReadyCnt, enableCnt;

    // Counts cycles spent not ready and cycles since enable rose.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            notReadyCnt <= 0;
            enableCnt <= 0;
        end else begin
            notReadyCnt <= deviceReady ? 0 : notReadyCnt + 1;
            enableCnt <= enable ? enableCnt + 1 : 0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer after one cycle");
    a_wait_back_high: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest stayed low");
    a_check_before_ready: assert property ($rose(deviceReady) |-> notReadyCnt >= CHECK_CYC)
        else $error("ready during check");
    a_quiet_while_busy: assert property (!deviceReady && !$past(deviceReady) |->
        outputTarget == '0 && !rampActive && !rampDone)
        else $error("output moved in check");
    a_ramp_monotonic: assert property (enable && $past(enable) && rampActive && $past(rampActive) |->
        outputTarget >= $past(outputTarget))
        else $error("ramp stepped backward");
    a_delay_floor: assert property ((outputTarget != '0) && ($past(outputTarget) == '0) |->
        enableCnt >= FLOOR_CYC)
        else $error("ramp before delay floor");
    a_target_off: assert property (!enable [*3] |-> outputTarget == '0)
        else $error("target set while disabled");
    a_done_holds: assert property (rampDone && $past(rampDone) && deviceReady |-> $stable(outputTarget))
        else $error("target moved after done");

    c_ready: cover property ($rose(deviceReady));
    c_ramp: cover property ($rose(rampActive));
    c_done: cover property ($rose(rampDone));
endmodule

bind startup_softstart_sequencer startup_sequencer_props #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .TARGET_WIDTH(TARGET_WIDTH)
) props (
    .core_clk(core_clk), .reset_n(reset_n), .enable(enable), .read(read), .write(write),
    .waitrequest(waitrequest), .deviceReady(deviceReady), .outputTarget(outputTarget),
    .rampActive(rampActive), .rampDone(rampDone)
);

// ---- host_system_model.sv ----
`timescale 1ns/1ps
module host_system_model (
    input wire core_clk,
    input wire waitrequest,
    input wire [31:0] readdata,
    output logic [4:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    output logic enable
);
    initial begin
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        enable = 1'b0;
    end

    task automatic busWrite(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        write <= 1'b0;
    endtask

    task automatic busRead(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        read <= 1'b1;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        d = readdata;
        read <= 1'b0;
    endtask

    // The core clock is already steady whenever enable is raised.
    task automatic setEnable(input logic v);
        @(posedge core_clk);
        enable <= v;
    endtask
endmodule

// ---- startup_softstart_sequencer_test.sv ----
`timescale 1ns/1ps
`include "startup_consts.vh"
module startup_softstart_sequencer_test;
    localparam int MS = 10;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] delaySelectLow = `SS_PIN_LOW;
    logic [1:0] delaySelectHigh = `SS_PIN_OPEN;
    logic [1:0] rampSelect = `SS_PIN_OPEN;
    logic delayResistorFound = 1'b0;
    logic rampResistorFound = 1'b0;
    logic [4:0] delayResistorCode, rampResistorCode;
    logic storedValid = 1'b0;
    logic [7:0] storedDelayMs, storedRampMs;
    logic enable, read, write, waitrequest, deviceReady, rampActive, rampDone;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, rd;
    logic [11:0] outputTarget;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n, t0;

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    startup_softstart_sequencer #(.CYCLES_PER_MS(MS)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .enable(enable), .delaySelectLow(delaySelectLow),
        .delaySelectHigh(delaySelectHigh), .rampSelect(rampSelect), .delayResistorFound(delayResistorFound),
        .delayResistorCode(delayResistorCode), .rampResistorFound(rampResistorFound),
        .rampResistorCode(rampResistorCode), .storedValid(storedValid), .storedDelayMs(storedDelayMs),
        .storedRampMs(storedRampMs), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .deviceReady(deviceReady),
        .outputTarget(outputTarget), .rampActive(rampActive), .rampDone(rampDone)
    );

    host_system_model host (
        .core_clk(core_clk), .waitrequest(waitrequest), .readdata(readdata), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .enable(enable)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic checkRange(input int got, input int lo, input int hi, input string msg);
        samples_checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[FAIL] %0t %s: %0d not in %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask

    task automatic readCheck(input logic [4:0] a, input logic [31:0] exp, input string msg);
        host.busRead(a, rd);
        check(rd, exp, msg);
    endtask

    task automatic waitReady;
        int k = 0;
        while (deviceReady !== 1'b1 && k < 500) begin
            @(posedge core_clk);
            k++;
        end
    endtask

    task automatic restore;
        host.busWrite(`SS_REG_CONTROL, 32'h00000001, 4'hF);
        @(posedge core_clk);
        waitReady();
    endtask

    task automatic measure(output int cnt);
        cnt = 0;
        while (outputTarget === 12'h000 && cnt < 5000) begin
            @(posedge core_clk);
            cnt++;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_startup;
        t0 = cyc;
        host.setEnable(1'b1);
        host.busWrite(`SS_REG_DELAY, 32'h00000077, 4'hF);
        repeat (20) @(posedge core_clk);
        check(outputTarget, 12'h000, "moved in check");
        host.setEnable(1'b0);
        waitReady();
        checkRange(cyc - t0, 5 * MS, 10 * MS + 5, "memory check length");
        readCheck(`SS_REG_DELAY, 32'h00000005, "dropped write");
        readCheck(`SS_REG_RAMP, 32'h00000005, "ramp strap");
        readCheck(`SS_REG_STATUS, 32'h00000004, "ready state");
        readCheck(`SS_REG_NOMINAL, 32'h00000800, "nominal reset");
        readCheck(`SS_REG_CONTROL, 32'h00000000, "control reset");
        readCheck(5'h1C, 32'h00000000, "unmapped read");
        $display("test_startup done");
    endtask

    task automatic test_straps;
        logic [7:0] dlyTab [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0A, 8'h14, 8'h32, 8'h64, 8'hC8};
        logic [7:0] rampTab [3] = '{8'h00, 8'h05, 8'h0A};
        for (int i = 0; i < 9; i++) begin
            delaySelectHigh <= 2'(i / 3);
            delaySelectLow <= 2'(i % 3);
            rampSelect <= 2'(i % 3);
            t0 = cyc;
            restore();
            checkRange(cyc - t0, 5 * MS, 10 * MS + 8, "restore check");
            readCheck(`SS_REG_DELAY, {24'h000000, dlyTab[i]}, "delay strap");
            readCheck(`SS_REG_RAMP, {24'h000000, rampTab[i % 3]}, "ramp strap");
        end
        delayResistorFound <= 1'b1;
        delayResistorCode <= 5'h07;
        rampResistorFound <= 1'b1;
        rampResistorCode <= 5'h19;
        restore();
        readCheck(`SS_REG_DELAY, 32'h00000046, "delay resistor");
        readCheck(`SS_REG_RAMP, 32'h000000C8, "ramp clamp");
        delayResistorCode <= 5'h03;
        repeat (2) @(posedge core_clk);
        readCheck(`SS_REG_DELAY, 32'h00000046, "remeasured");
        storedDelayMs <= 8'h03;
        storedRampMs <= 8'h06;
        storedValid <= 1'b1;
        restore();
        readCheck(`SS_REG_DELAY, 32'h00000003, "stored delay");
        readCheck(`SS_REG_STATUS, 32'h00000104, "loaded flag");
        $display("test_straps done");
    endtask

    task automatic test_floor;
        for (int d = 0; d < 2; d++) begin
            host.busWrite(`SS_REG_DELAY, 32'(d), 4'hF);
            host.busWrite(`SS_REG_RAMP, 32'h00000000, 4'hF);
            readCheck(`SS_REG_DELAY, 32'(d), "custom delay");
            host.setEnable(1'b1);
            measure(n);
            checkRange(n, 2 * MS, 3 * MS + 6, "delay floor");
            check(outputTarget, 12'h800, "zero ramp step");
            repeat (2) @(posedge core_clk);
            check(rampDone, 1'b1, "done after step");
            host.setEnable(1'b0);
            repeat (4) @(posedge core_clk);
            check(outputTarget, 12'h000, "target after disable");
        end
        $display("test_floor done");
    endtask

    task automatic test_delay_modes;
        for (int p = 1; p >= 0; p--) begin
            host.busWrite(`SS_REG_CONTROL, 32'(p * 2), 4'hF);
            host.busWrite(`SS_REG_DELAY, 32'h00000003, 4'hF);
            host.busWrite(`SS_REG_DELAY, 32'h000000FF, 4'h0);
            readCheck(`SS_REG_DELAY, 32'h00000003, "masked byte lanes");
            readCheck(`SS_REG_CONTROL, 32'(p * 2), "precise bit");
            host.setEnable(1'b1);
            measure(n);
            if (p == 1) begin
                checkRange(n, 3 * MS, 3 * MS + 6, "precise delay");
            end else begin
                checkRange(n, 3 * MS, 4 * MS + 6, "free delay");
            end
            host.setEnable(1'b0);
            repeat (4) @(posedge core_clk);
        end
        $display("test_delay_modes done");
    endtask

    task automatic test_ramp;
        host.busWrite(`SS_REG_RAMP, 32'h00000005, 4'hF);
        host.busWrite(`SS_REG_NOMINAL, 32'h000000C8, 4'hF);
        host.setEnable(1'b1);
        n = 0;
        while (rampActive !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        while (rampDone !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
            if (n == 2 * MS) checkRange(outputTarget, 1, 12'h0C7, "ramp midpoint");
        end
        checkRange(n, 5 * MS - 3, 5 * MS + 3, "ramp length");
        check(outputTarget, 12'h0C8, "ramp end");
        restore();
        check(outputTarget, 12'h000, "restore clear");
        readCheck(`SS_REG_RAMP, 32'h00000006, "reload");
        host.setEnable(1'b0);
        $display("test_ramp done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        test_startup();
        test_straps();
        test_floor();
        test_delay_modes();
        test_ramp();
        tally_and_finish();
    end

    initial begin
        #(100 * 20000);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
